// *** error_status_pkg.sv ***
// Purpose: Shared constants and types for the controller error status unit.
// Assumes: 25 MHz system clock, 16-bit register port.
// Notes: Register offsets are word indices on the plain register port.
`default_nettype none
package error_status_pkg;
    // Clock and watchdog timing
    localparam int CLK_HZ = 25_000_000;
    localparam int WDOG_LIMIT_MS = 100;
    localparam int WDOG_CYCLES = WDOG_LIMIT_MS * (CLK_HZ / 1000);

    // Register offsets
    localparam logic [3:0] GEF_OFFS = 4'h0;
    localparam logic [3:0] EEC_OFFS = 4'h1;
    localparam logic [3:0] CFG_OFFS = 4'h2;
    localparam logic [3:0] IRQ_STAT_OFFS = 4'h3;
    localparam logic [3:0] IRQ_MASK_OFFS = 4'h4;
    localparam logic [3:0] RUN_STAT_OFFS = 4'h5;

    // Field positions of general_error_flags
    localparam int POWER_BIT = 0;
    localparam int WDOG_BIT = 1;
    localparam int PRESET_BIT = 4;
    localparam int KEEP_BIT = 6;
    localparam int SYNTAX_BIT = 7;
    localparam int EXEC_BIT = 13;
    localparam int CLEAR_BIT = 15;
    localparam logic [15:0] GEF_IMPL_MASK = 16'h20D3;

    // Field positions of config and run status
    localparam int CFG_KEEP_STOP_BIT = 0;
    localparam int RUN_STOP_BIT = 0;
    localparam int RUN_OUTOFF_BIT = 1;
    localparam int RUN_RELAY_BIT = 2;
    localparam int RUN_ROMCRC_BIT = 3;

    // Interrupt event bits
    localparam int IRQ_EVENTS = 7;
    localparam int EV_POWER = 0;
    localparam int EV_WDOG = 1;
    localparam int EV_PRESET = 2;
    localparam int EV_KEEP = 3;
    localparam int EV_SYNTAX = 4;
    localparam int EV_EXEC = 5;
    localparam int EV_PARTS = 6;

    // Reset values
    localparam logic [15:0] GEF_RESET = 16'h0000;
    localparam logic [7:0] EEC_RESET = 8'h00;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] MASK_RESET = 16'h0000;

    // Fault reports from the rest of the controller, one-cycle pulses
    typedef struct packed {
        logic powerOff;
        logic presetSum;
        logic keepSum;
        logic syntax;
        logic romCrc;
        logic execErr;
        logic partsComm;
    } fault_ev_t;

    // Reactions driven back into the controller
    typedef struct packed {
        logic stopRun;
        logic outputsOff;
        logic reloadPresets;
        logic clearRetained;
    } action_t;

    // Deferred clear sequencing
    typedef enum logic [0:0] {
        CLR_IDLE = 1'b0,
        CLR_WAIT = 1'b1
    } clr_state_t;
endpackage
`default_nettype wire

// *** controller_error_status_unit.sv ***
// Purpose: Error flags, execution code, watchdog and stop decisions.
// Assumes: Scan start/end pulses and fault pulses come from clk logic.
// Notes: Power-fail pin is asynchronous and is synchronised here.
// What this block does
// - flag bit reads one while error present
// - bit0 on low supply or power off
// - watchdog sets bit1 when scan overruns
// - bit4 on preset checksum, reload presets
// - bit6 on keep checksum, clear retained data
// - bit7 on program syntax error
// - bit13 and relay flag on execution error
// - separate execution error code register
// - clear bit clears flags and code
// - clear takes effect at scan end
// - parts and communication errors not cleared
// - fatal errors stop and force outputs off
// - keep fault runs unless option says stop
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module controller_error_status_unit #(
    parameter int WDOG_MAX = error_status_pkg::WDOG_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Asynchronous supply monitor pin, high while voltage is low
    input wire logic powerLowPin,
    // Scan sequencer
    input wire logic scanStart,
    input wire logic scanEnd,
    // Fault reports
    input wire error_status_pkg::fault_ev_t faultEv,
    input wire logic [7:0] execCode,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    // Reactions
    output error_status_pkg::action_t action,
    output logic exec_error_relay_flag,
    output logic irq
);
    logic powerSync1;
    logic powerSync2;
    logic [15:0] general_error_flags;
    logic [7:0] exec_error_code;
    logic [15:0] cfgReg;
    logic [15:0] irqStat;
    logic [15:0] irqMask;
    logic romCrcFault;
    logic inScan;
    logic [31:0] wdogCount;
    logic wdogTrip;
    logic clearNow;
    logic clearReq;
    error_status_pkg::clr_state_t clrState;
    error_status_pkg::clr_state_t next_clrState;
    logic [15:0] flagSet;
    logic [15:0] evSet;
    logic keepStop;
    logic stopAll;

    // Two-stage synchroniser for the supply monitor pin
    always_ff @(posedge clk) begin
        if (rst) begin
            powerSync1 <= 1'b0;
            powerSync2 <= 1'b0;
        end else begin
            powerSync1 <= powerLowPin;
            powerSync2 <= powerSync1;
        end
    end

    // Scan watchdog; trips once per overrunning scan
    always_ff @(posedge clk) begin
        if (rst) begin
            inScan <= 1'b0;
            wdogCount <= 32'h0000_0000;
        end else if (scanStart) begin
            inScan <= 1'b1;
            wdogCount <= 32'h0000_0000;
        end else if (scanEnd) begin
            inScan <= 1'b0;
        end else if (inScan && wdogCount != 32'(WDOG_MAX)) begin
            wdogCount <= wdogCount + 32'h0000_0001;
        end
    end
    assign wdogTrip = inScan && !scanEnd && !scanStart
        && wdogCount == 32'(WDOG_MAX - 1);

    // Clear request is held until the scan ends
    assign clearReq = regWr && regAddr == error_status_pkg::GEF_OFFS
        && regWdata[error_status_pkg::CLEAR_BIT];
    always_comb begin
        next_clrState = clrState;
        case (clrState)
            error_status_pkg::CLR_IDLE: begin
                if (clearReq) begin
                    next_clrState = error_status_pkg::CLR_WAIT;
                end
            end
            error_status_pkg::CLR_WAIT: begin
                if (scanEnd) begin
                    next_clrState = error_status_pkg::CLR_IDLE;
                end
            end
            default: next_clrState = error_status_pkg::CLR_IDLE;
        endcase
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            clrState <= error_status_pkg::CLR_IDLE;
        end else begin
            clrState <= next_clrState;
        end
    end
    assign clearNow = clrState == error_status_pkg::CLR_WAIT
        && scanEnd;

    // Set terms per flag bit
    always_comb begin
        flagSet = 16'h0000;
        flagSet[error_status_pkg::POWER_BIT] = powerSync2
            || faultEv.powerOff;
        flagSet[error_status_pkg::WDOG_BIT] = wdogTrip;
        flagSet[error_status_pkg::PRESET_BIT] = faultEv.presetSum;
        flagSet[error_status_pkg::KEEP_BIT] = faultEv.keepSum;
        flagSet[error_status_pkg::SYNTAX_BIT] = faultEv.syntax;
        flagSet[error_status_pkg::EXEC_BIT] = faultEv.execErr;
    end

    // Error flags: set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            general_error_flags <= error_status_pkg::GEF_RESET;
        end else if (clearNow) begin
            general_error_flags <= flagSet;
        end else begin
            general_error_flags <= general_error_flags | flagSet;
        end
    end

    // Execution code and relay flag, cleared with the flags
    always_ff @(posedge clk) begin
        if (rst) begin
            exec_error_code <= error_status_pkg::EEC_RESET;
            exec_error_relay_flag <= 1'b0;
        end else if (faultEv.execErr) begin
            exec_error_code <= execCode;
            exec_error_relay_flag <= 1'b1;
        end else if (clearNow) begin
            exec_error_code <= error_status_pkg::EEC_RESET;
            exec_error_relay_flag <= 1'b0;
        end
    end

    // ROM CRC has no flag bit but still halts until cleared
    always_ff @(posedge clk) begin
        if (rst) begin
            romCrcFault <= 1'b0;
        end else if (faultEv.romCrc) begin
            romCrcFault <= 1'b1;
        end else if (clearNow) begin
            romCrcFault <= 1'b0;
        end
    end

    // Stop decision
    assign keepStop = cfgReg[error_status_pkg::CFG_KEEP_STOP_BIT]
        && general_error_flags[error_status_pkg::KEEP_BIT];
    assign stopAll = general_error_flags[error_status_pkg::POWER_BIT]
        || general_error_flags[error_status_pkg::WDOG_BIT]
        || general_error_flags[error_status_pkg::SYNTAX_BIT]
        || romCrcFault || keepStop;

    // Reactions come from flops so the controller sees clean levels
    always_ff @(posedge clk) begin
        if (rst) begin
            action <= '0;
        end else begin
            action.stopRun <= stopAll;
            action.outputsOff <= stopAll;
            action.reloadPresets <= faultEv.presetSum;
            action.clearRetained <= faultEv.keepSum;
        end
    end

    // Config and mask registers
    always_ff @(posedge clk) begin
        if (rst) begin
            cfgReg <= error_status_pkg::CFG_RESET;
            irqMask <= error_status_pkg::MASK_RESET;
        end else if (regWr) begin
            if (regAddr == error_status_pkg::CFG_OFFS) begin
                cfgReg <= regWdata & 16'h0001;
            end
            if (regAddr == error_status_pkg::IRQ_MASK_OFFS) begin
                irqMask <= regWdata & 16'h007F;
            end
        end
    end

    // Interrupt events; parts errors live only here, untouched by clear
    always_comb begin
        evSet = 16'h0000;
        evSet[error_status_pkg::EV_POWER] =
            flagSet[error_status_pkg::POWER_BIT];
        evSet[error_status_pkg::EV_WDOG] = wdogTrip;
        evSet[error_status_pkg::EV_PRESET] = faultEv.presetSum;
        evSet[error_status_pkg::EV_KEEP] = faultEv.keepSum;
        evSet[error_status_pkg::EV_SYNTAX] = faultEv.syntax;
        evSet[error_status_pkg::EV_EXEC] = faultEv.execErr;
        evSet[error_status_pkg::EV_PARTS] = faultEv.partsComm;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            irqStat <= 16'h0000;
        end else if (regWr && regAddr == error_status_pkg::IRQ_STAT_OFFS) begin
            irqStat <= (irqStat & ~regWdata) | evSet;
        end else begin
            irqStat <= irqStat | evSet;
        end
    end
    assign irq = |(irqStat & irqMask);

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (rst || !regRd) begin
            regRdata <= 16'h0000;
        end else begin
            case (regAddr)
                error_status_pkg::GEF_OFFS: begin
                    regRdata <= (general_error_flags
                        & error_status_pkg::GEF_IMPL_MASK)
                        | {clrState == error_status_pkg::CLR_WAIT,
                        15'h0000};
                end
                error_status_pkg::EEC_OFFS: begin
                    regRdata <= {8'h00, exec_error_code};
                end
                error_status_pkg::CFG_OFFS: regRdata <= cfgReg;
                error_status_pkg::IRQ_STAT_OFFS: regRdata <= irqStat;
                error_status_pkg::IRQ_MASK_OFFS: regRdata <= irqMask;
                error_status_pkg::RUN_STAT_OFFS: begin
                    regRdata <= {12'h000, romCrcFault,
                        exec_error_relay_flag, action.outputsOff,
                        action.stopRun};
                end
                default: regRdata <= 16'h0000;
            endcase
        end
    end

    // Checks
    power_flag_a: assert property (@(posedge clk) disable iff (rst)
        $rose(powerSync2) |=> general_error_flags[0])
        else $error("power flag not set");
    wdog_trip_a: assert property (@(posedge clk) disable iff (rst)
        wdogTrip |=> general_error_flags[1])
        else $error("watchdog flag not set");
    preset_reload_a: assert property (@(posedge clk) disable iff (rst)
        faultEv.presetSum && !stopAll |=> action.reloadPresets
        && general_error_flags[4] && !action.stopRun)
        else $error("preset fault handling wrong");
    keep_clear_a: assert property (@(posedge clk) disable iff (rst)
        faultEv.keepSum |=> action.clearRetained && general_error_flags[6])
        else $error("keep fault handling wrong");
    syntax_stop_a: assert property (@(posedge clk) disable iff (rst)
        faultEv.syntax |=> ##1 action.stopRun && action.outputsOff)
        else $error("syntax error did not stop");
    exec_relay_a: assert property (@(posedge clk) disable iff (rst)
        faultEv.execErr |=> exec_error_relay_flag && general_error_flags[13]
        && exec_error_code == $past(execCode))
        else $error("exec error not recorded");
    clear_defer_a: assert property (@(posedge clk) disable iff (rst)
        clrState == error_status_pkg::CLR_WAIT && !scanEnd
        && general_error_flags[7] |=> general_error_flags[7])
        else $error("flags cleared before scan end");
    clear_done_a: assert property (@(posedge clk) disable iff (rst)
        clearNow && !faultEv.execErr |=> exec_error_code == 8'h00
        && general_error_flags == $past(flagSet))
        else $error("clear incomplete");
    parts_keep_a: assert property (@(posedge clk) disable iff (rst)
        irqStat[6] && clearNow && !(regWr && regAddr == 4'h3) |=> irqStat[6])
        else $error("parts error lost on clear");
    reserved_zero_a: assert property (@(posedge clk)
        disable iff (rst)
        $past(regRd) && $past(regAddr) == 4'h0 |-> (regRdata & 16'h5F2C) == 0)
        else $error("reserved bit read nonzero");
    keep_run_a: assert property (@(posedge clk) disable iff (rst)
        faultEv.keepSum && !cfgReg[0] && !stopAll && flagSet[1:0] == 2'b00
        && !faultEv.syntax && !faultEv.romCrc
        && !(regWr && regAddr == error_status_pkg::CFG_OFFS)
        |=> ##1 !action.stopRun)
        else $error("keep fault stopped by default");

    // Sticky flags and held code between sets and clears, relay dropped by clear
    flags_sticky_a: assert property (@(posedge clk) disable iff (rst)
        !clearNow |=> (general_error_flags & $past(general_error_flags))
        == $past(general_error_flags))
        else $error("error flag dropped without clear");
    code_hold_a: assert property (@(posedge clk) disable iff (rst)
        !faultEv.execErr && !clearNow |=> $stable(exec_error_code))
        else $error("execution code changed unasked");
    relay_clear_a: assert property (@(posedge clk) disable iff (rst)
        clearNow && !faultEv.execErr |=> !exec_error_relay_flag)
        else $error("relay flag survived clear");
    power_hold_a: assert property (@(posedge clk) disable iff (rst)
        powerSync2 |=> general_error_flags[0])
        else $error("power flag lost while supply low");

    // Stop reactions: fatal faults halt, a keep fault halts only with the stop option, preset and execution faults keep the scan going
    fatal_stop_a: assert property (@(posedge clk) disable iff (rst)
        (general_error_flags & 16'h0083) != 16'h0000 || romCrcFault
        |=> action.stopRun && action.outputsOff)
        else $error("fatal fault did not stop");
    keep_option_a: assert property (@(posedge clk) disable iff (rst)
        cfgReg[0] && general_error_flags[6]
        |=> action.stopRun && action.outputsOff)
        else $error("keep fault ignored stop option");
    nonfatal_run_a: assert property (@(posedge clk) disable iff (rst)
        (general_error_flags & 16'h2010) != 16'h0000
        && (general_error_flags & 16'h00C3) == 16'h0000 && !romCrcFault
        |=> !action.stopRun && !action.outputsOff)
        else $error("non-fatal fault stopped operation");
    wdog_once_a: assert property (@(posedge clk) disable iff (rst)
        wdogTrip |=> !wdogTrip)
        else $error("watchdog tripped twice");

    // Register port: clear bit returns, read data stands one cycle only
    clear_return_a: assert property (@(posedge clk) disable iff (rst)
        clearNow |=> ##1 !regRdata[15])
        else $error("clear bit did not return");
    rdata_idle_a: assert property (@(posedge clk) disable iff (rst)
        !$past(regRd) |-> regRdata == 16'h0000)
        else $error("read data outside its cycle");

    // Main scenarios worth seeing at least once
    clear_seen_c: cover property (@(posedge clk) disable iff (rst)
        clearReq ##[1:50] clearNow);
    wdog_seen_c: cover property (@(posedge clk) disable iff (rst) wdogTrip);
    keep_stop_c: cover property (@(posedge clk) disable iff (rst) keepStop);
    set_clear_c: cover property (@(posedge clk) disable iff (rst)
        clearNow && |flagSet);
    keep_run_c: cover property (@(posedge clk) disable iff (rst)
        general_error_flags[6] && !action.stopRun);
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Purpose: Self-checking bench for the controller error status unit.
// Assumes: Watchdog limit shortened to 20 cycles, one 25 MHz clock.
// Notes: Register reads are sampled just after the edge that lands them.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [6:0] POWEROFF = 7'h40;
    localparam logic [6:0] PRESET = 7'h20;
    localparam logic [6:0] KEEP = 7'h10;
    localparam logic [6:0] SYNTAX = 7'h08;
    localparam logic [6:0] ROMCRC = 7'h04;
    localparam logic [6:0] EXEC = 7'h02;
    localparam logic [6:0] PARTS = 7'h01;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic powerLowPin = 1'b0;
    logic scanStart = 1'b0;
    logic scanEnd = 1'b0;
    error_status_pkg::fault_ev_t faultEv = '0;
    logic [7:0] execCode = 8'h00;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] regRdata;
    error_status_pkg::action_t action;
    logic exec_error_relay_flag;
    logic irq;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [15:0] rdat;

    controller_error_status_unit #(.WDOG_MAX(20))
        u_controller_error_status_unit (
        .clk(clk), .rst(rst), .powerLowPin(powerLowPin),
        .scanStart(scanStart), .scanEnd(scanEnd), .faultEv(faultEv),
        .execCode(execCode), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .action(action), .exec_error_relay_flag(exec_error_relay_flag),
        .irq(irq));

    // Free-running system clock
    always #20 clk = ~clk;

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            $display("MISMATCH at %0t: run did not finish", $time);
            close_out();
        end
    end

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    // Strobe one cycle, data stands only in the next one
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask

    task automatic fire(input logic [6:0] ev);
        @(posedge clk);
        faultEv <= error_status_pkg::fault_ev_t'(ev);
        @(posedge clk);
        faultEv <= '0;
    endtask

    task automatic pulse_end();
        @(posedge clk);
        scanEnd <= 1'b1;
        @(posedge clk);
        scanEnd <= 1'b0;
    endtask

    // Request the clear, then let the scan end carry it out
    task automatic clear_all();
        wr(error_status_pkg::GEF_OFFS, 16'h8000);
        pulse_end();
        rd(error_status_pkg::GEF_OFFS, rdat);
        chk(rdat, 16'h0000);
    endtask

    task automatic test_reset_map();
        rd(error_status_pkg::GEF_OFFS, rdat);
        chk(rdat, error_status_pkg::GEF_RESET);
        rd(error_status_pkg::IRQ_MASK_OFFS, rdat);
        chk(rdat, error_status_pkg::MASK_RESET);
        wr(error_status_pkg::GEF_OFFS, 16'h7FFF);
        rd(error_status_pkg::GEF_OFFS, rdat);
        chk(rdat, 16'h0000);
        rd(4'hF, rdat);
        chk(rdat, 16'h0000);
        $display("Test reset_map done");
    endtask

    task automatic test_power();
        @(posedge clk);
        powerLowPin <= 1'b1;
        repeat (5) @(posedge clk);
        rd(error_status_pkg::GEF_OFFS, rdat);
        chk(rdat, 16'h0001);
        rd(error_status_pkg::RUN_STAT_OFFS, rdat);
        chk(rdat, 16'h0003);
        @(posedge clk);
        powerLowPin <= 1'b0;
        repeat (4) @(posedge clk);
        clear_all();
        rd(error_status_pkg::RUN_STAT_OFFS, rdat);
        chk(rdat, 16'h0000);
        // Switch-off report sets the same flag as a low supply
        fire(POWEROFF);
        rd(error_status_pkg::GEF_OFFS, rdat);
        chk(rdat, 16'h0001);
        clear_all();
        $display("Test power done");
    endtask

    task automatic test_watchdog();
        @(posedge clk);
        scanStart <= 1'b1;
        @(posedge clk);
        scanStart <= 1'b0;
        repeat (10) @(posedge clk);
        pulse_end();
        repeat (20) @(posedge clk);
        rd(error_status_pkg::GEF_OFFS, rdat);
        chk(rdat, 16'h0000);
        @(posedge clk);
        scanStart <= 1'b1;
        @(posedge clk);
        scanStart <= 1'b0;
        repeat (25) @(posedge clk);
        rd(error_status_pkg::GEF_OFFS, rdat);
        chk(rdat, 16'h0002);
        rd(error_status_pkg::RUN_STAT_OFFS, rdat);
        chk(rdat, 16'h0003);
        clear_all();
        $display("Test watchdog done");
    endtask

    // Preset and execution faults never stop the controller
    task automatic test_nonstop();
        fire(PRESET);
        #1;
        chk({15'h0000, action.reloadPresets}, 16'h0001);
        @(posedge clk);
        execCode <= 8'h1D;
        fire(EXEC);
        rd(error_status_pkg::GEF_OFFS, rdat);
        chk(rdat, 16'h2010);
        rd(error_status_pkg::EEC_OFFS, rdat);
        chk(rdat, 16'h001D);
        chk({15'h0000, exec_error_relay_flag}, 16'h0001);
        rd(error_status_pkg::RUN_STAT_OFFS, rdat);
        chk(rdat, 16'h0004);
        fire(PARTS);
        wr(error_status_pkg::GEF_OFFS, 16'h8000);
        rd(error_status_pkg::GEF_OFFS, rdat);
        chk(rdat, 16'hA010);
        clear_all();
        rd(error_status_pkg::EEC_OFFS, rdat);
        chk(rdat, 16'h0000);
        chk({15'h0000, exec_error_relay_flag}, 16'h0000);
        rd(error_status_pkg::IRQ_STAT_OFFS, rdat);
        chk(rdat & 16'h0040, 16'h0040);
        $display("Test nonstop done");
    endtask

    task automatic test_stops();
        fire(SYNTAX);
        rd(error_status_pkg::GEF_OFFS, rdat);
        chk(rdat, 16'h0080);
        rd(error_status_pkg::RUN_STAT_OFFS, rdat);
        chk(rdat, 16'h0003);
        clear_all();
        fire(ROMCRC);
        rd(error_status_pkg::RUN_STAT_OFFS, rdat);
        chk(rdat, 16'h000B);
        clear_all();
        $display("Test stops done");
    endtask

    // Retained-data fault: run by default, stop when configured
    task automatic test_keep();
        fire(KEEP);
        #1;
        chk({15'h0000, action.clearRetained}, 16'h0001);
        rd(error_status_pkg::GEF_OFFS, rdat);
        chk(rdat, 16'h0040);
        rd(error_status_pkg::RUN_STAT_OFFS, rdat);
        chk(rdat, 16'h0000);
        clear_all();
        wr(error_status_pkg::CFG_OFFS, 16'h0001);
        fire(KEEP);
        rd(error_status_pkg::RUN_STAT_OFFS, rdat);
        chk(rdat, 16'h0003);
        clear_all();
        wr(error_status_pkg::CFG_OFFS, 16'h0000);
        $display("Test keep done");
    endtask

    task automatic test_irq();
        wr(error_status_pkg::IRQ_STAT_OFFS, 16'h007F);
        fire(PRESET);
        rd(error_status_pkg::IRQ_STAT_OFFS, rdat);
        chk(rdat, 16'h0004);
        chk({15'h0000, irq}, 16'h0000);
        wr(error_status_pkg::IRQ_MASK_OFFS, 16'h0004);
        #1;
        chk({15'h0000, irq}, 16'h0001);
        wr(error_status_pkg::IRQ_STAT_OFFS, 16'h0004);
        #1;
        chk({15'h0000, irq}, 16'h0000);
        clear_all();
        $display("Test irq done");
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        test_reset_map();
        test_power();
        test_watchdog();
        test_nonstop();
        test_stops();
        test_keep();
        test_irq();
        close_out();
    end
endmodule
`default_nettype wire
